// file: hdl/mram_port_regs.vh
// Summary of operation
// R1 - Write: select and write strobe low; address and data lines carry the word.
// R2 - Read: select and output enable low, write strobe high; device drives word.
// R3 - Device floats data when deselected or with strobes high; output enable ignored in writes.
// R4 - Largest density: two banks of four dies, each with own select.
// R5 - Hold selects high while supply power is coming up.
// R6 - Wait power-up delay, 1 ms, before first access after power-up or brownout.
// R7 - Hold selects high while supply power is going down.
// R8 - Issue no accesses while core supply is below its minimum level.
// R9 - Supply below 1.6 V cutoff: redo the full power-up wait.
// R10 - Assert at most one bank select at any time.
// R11 - During the power-up wait all selects stay high; accesses released afterwards.
`ifndef MRAM_PORT_REGS_VH
`define MRAM_PORT_REGS_VH
`define CLK_FREQ_HZ      25000000
`define POWER_UP_US      1000
`define POWER_UP_CYCLES  ((`CLK_FREQ_HZ / 1000000) * `POWER_UP_US)
`define SETUP_CYCLES     2
`define STROBE_CYCLES    4
`define HOLD_CYCLES      2
`define ADDR_BITS        27
`define DATA_BITS        32
`define DIE_BANKS        2
`endif

// file: hdl/power_gate_timer.v
`timescale 1ns/1ps
`default_nettype none
module power_gate_timer #(
  parameter integer WAIT_CYCLES = 25000
) (
  // Clock and reset
  input  wire sys_clk,
  input  wire sys_rst,
  // Supply status
  input  wire power_good,
  input  wire below_cutoff,
  // Result
  output reg  ready
);
  reg [31:0] count;

  // Any supply dip restarts the whole wait
  always @(posedge sys_clk)
  begin
    if (sys_rst || !power_good || below_cutoff) // R6 R9
    begin
      count <= 32'h0000_0000;
      ready <= 1'b0;
    end
    else if (!ready)
    begin
      if (count >= WAIT_CYCLES - 1)
        ready <= 1'b1; // R6
      count <= count + 32'h0000_0001;
    end
  end
endmodule // power_gate_timer
`default_nettype wire

// file: hdl/mram_host_port.v
`include "mram_port_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module mram_host_port #(
  parameter integer POWER_UP_CYCLES = `POWER_UP_CYCLES,
  parameter integer SETUP_CYCLES    = `SETUP_CYCLES,
  parameter integer STROBE_CYCLES   = `STROBE_CYCLES,
  parameter integer HOLD_CYCLES     = `HOLD_CYCLES
) (
  // Clock and reset
  input  wire                    sys_clk,
  input  wire                    sys_rst,
  // Supply monitors
  input  wire                    power_good,
  input  wire                    below_cutoff,
  // User request
  input  wire                    req_valid,
  input  wire                    req_write,
  input  wire                    req_bank,
  input  wire [`ADDR_BITS-1:0]   req_addr,
  input  wire [`DATA_BITS-1:0]   req_wdata,
  output reg                     req_ready,
  output reg                     rsp_valid,
  output reg  [`DATA_BITS-1:0]   rsp_rdata,
  output reg                     mem_ready,
  // Memory pins
  output reg                     bank_one_select_n,
  output reg                     bank_two_select_n,
  output reg                     write_strobe_n,
  output reg                     output_enable_n,
  output reg  [`ADDR_BITS-1:0]   mem_addr,
  output reg  [`DATA_BITS-1:0]   dq_out,
  output reg                     dq_oe,
  input  wire [`DATA_BITS-1:0]   dq_in
);
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_SETUP  = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD   = 3'h3;

  // Sequencer state
  reg  [2:0]             state;
  reg  [15:0]            count;
  reg                    is_write;
  wire                   powered;
  wire                   quiet;

  // Next values
  reg  [2:0]             next_state;
  reg  [15:0]            next_count;
  reg                    next_is_write;
  reg                    next_req_ready;
  reg                    next_rsp_valid;
  reg  [`DATA_BITS-1:0]  next_rsp_rdata;
  reg                    next_bank_one_select_n;
  reg                    next_bank_two_select_n;
  reg                    next_write_strobe_n;
  reg                    next_output_enable_n;
  reg  [`ADDR_BITS-1:0]  next_mem_addr;
  reg  [`DATA_BITS-1:0]  next_dq_out;
  reg                    next_dq_oe;

  // Phase bookkeeping
  reg  [31:0]            phase_last;
  wire                   phase_done;
  wire                   take;

  power_gate_timer #(
    .WAIT_CYCLES (POWER_UP_CYCLES)
  ) u_timer (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .power_good   (power_good),
    .below_cutoff (below_cutoff),
    .ready        (powered)
  );

  // No access of any kind until the supply has been good for the full wait
  assign quiet = sys_rst || !powered; // R8 R11

  // Last count value of each timed phase
  always @*
  begin
    case (state)
      ST_SETUP:  phase_last = SETUP_CYCLES - 1;
      ST_STROBE: phase_last = STROBE_CYCLES - 1;
      ST_HOLD:   phase_last = HOLD_CYCLES - 1;
      default:   phase_last = 32'h0000_0000;
    endcase
  end

  assign phase_done = ({16'h0000, count} >= phase_last);
  assign take       = req_valid && req_ready;

  // Access sequencer
  always @*
  begin
    next_state             = state;
    next_count             = count;
    next_is_write          = is_write;
    next_req_ready         = req_ready;
    next_rsp_valid         = 1'b0;
    next_rsp_rdata         = rsp_rdata;
    next_bank_one_select_n = bank_one_select_n;
    next_bank_two_select_n = bank_two_select_n;
    next_write_strobe_n    = write_strobe_n;
    next_output_enable_n   = output_enable_n;
    next_mem_addr          = mem_addr;
    next_dq_out            = dq_out;
    next_dq_oe             = dq_oe;
    case (state)
      ST_IDLE:
      begin
        next_req_ready = 1'b1;
        if (take)
        begin
          next_req_ready = 1'b0;
          next_is_write  = req_write;
          next_mem_addr  = req_addr;
          next_dq_out    = req_wdata;
          next_dq_oe     = req_write; // R1
          // Only one bank select at a time
          next_bank_one_select_n = req_bank; // R4 R10
          next_bank_two_select_n = ~req_bank; // R4 R10
          next_count     = 16'h0000;
          next_state     = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        next_count = count + 16'h0001;
        if (phase_done)
        begin
          next_count = 16'h0000;
          if (is_write)
            next_write_strobe_n = 1'b0; // R1
          else
            next_output_enable_n = 1'b0; // R2
          next_state = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        next_count = count + 16'h0001;
        if (phase_done)
        begin
          next_count           = 16'h0000;
          next_write_strobe_n  = 1'b1;
          next_output_enable_n = 1'b1;
          next_rsp_valid       = 1'b1;
          // Sample before output enable rises
          if (!is_write)
            next_rsp_rdata = dq_in; // R2
          next_state = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        next_count = count + 16'h0001;
        if (phase_done)
        begin
          // Data held past strobe release, then bus released
          next_count             = 16'h0000;
          next_dq_oe             = 1'b0; // R3
          next_bank_one_select_n = 1'b1;
          next_bank_two_select_n = 1'b1;
          next_state             = ST_IDLE;
        end
      end
      default:
      begin
        // Unknown code: release the bus and start over
        next_state             = ST_IDLE;
        next_req_ready         = 1'b0;
        next_bank_one_select_n = 1'b1;
        next_bank_two_select_n = 1'b1;
        next_write_strobe_n    = 1'b1;
        next_output_enable_n   = 1'b1;
        next_dq_oe             = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge sys_clk)
  begin
    if (quiet)
    begin
      state    <= ST_IDLE;
      count    <= 16'h0000;
      is_write <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      count    <= next_count;
      is_write <= next_is_write;
    end
  end

  // User side outputs
  always @(posedge sys_clk)
  begin
    if (quiet)
    begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 32'h0000_0000;
      mem_ready <= 1'b0;
    end
    else
    begin
      req_ready <= next_req_ready;
      rsp_valid <= next_rsp_valid;
      rsp_rdata <= next_rsp_rdata;
      mem_ready <= 1'b1;
    end
  end

  // Memory pins; a supply dip cuts any access short with selects high
  always @(posedge sys_clk)
  begin
    if (quiet) // R5 R7
    begin
      bank_one_select_n <= 1'b1; // R5 R11
      bank_two_select_n <= 1'b1;
      write_strobe_n    <= 1'b1;
      output_enable_n   <= 1'b1;
      mem_addr          <= 27'h000_0000;
      dq_out            <= 32'h0000_0000;
      dq_oe             <= 1'b0;
    end
    else
    begin
      bank_one_select_n <= next_bank_one_select_n;
      bank_two_select_n <= next_bank_two_select_n;
      write_strobe_n    <= next_write_strobe_n;
      output_enable_n   <= next_output_enable_n;
      mem_addr          <= next_mem_addr;
      dq_out            <= next_dq_out;
      dq_oe             <= next_dq_oe;
    end
  end
endmodule // mram_host_port
`default_nettype wire

// file: testbench/mram_host_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mram_host_port_assertions (
  input wire logic sys_clk, sys_rst, power_good, below_cutoff,
  input wire logic req_valid, req_write, req_bank, req_ready, rsp_valid, mem_ready, dq_oe,
  input wire logic bank_one_select_n, bank_two_select_n, write_strobe_n, output_enable_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic sel = !bank_one_select_n || !bank_two_select_n;
  wire logic take = req_valid && req_ready;
  AST_ONE_BANK: assert property (bank_one_select_n || bank_two_select_n)
    else $error("both banks selected");
  AST_DESEL: assert property (!mem_ready |-> !sel && !req_ready)
    else $error("select or request while unpowered");
  AST_LOSS: assert property ((!power_good || below_cutoff) |-> ##2 (!mem_ready && !sel))
    else $error("access kept after supply loss");
  AST_WR: assert property (!write_strobe_n |-> sel && dq_oe && output_enable_n)
    else $error("bad write phase");
  AST_RD: assert property (!output_enable_n |-> sel && write_strobe_n && !dq_oe)
    else $error("bad read phase");
  AST_ANSWER: assert property (take |-> ##7 rsp_valid)
    else $error("answer late");
  AST_BANK: assert property (take |=> ($past(req_bank) ? !bank_two_select_n : !bank_one_select_n))
    else $error("wrong bank");
  AST_RD_KIND: assert property (take && !req_write |-> ##3 !output_enable_n)
    else $error("read strobe missing");
  AST_STROBE: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*4] ##1 write_strobe_n)
    else $error("strobe length");
  cover property (take && req_write);
  cover property (take && !req_write);
  cover property ($rose(mem_ready));
  cover property (take && req_bank);
endmodule // mram_host_port_assertions
`default_nettype wire

// file: testbench/mram_model.sv
`timescale 1ns/1ps
`default_nettype none
module mram_model (
  input wire logic        sel1_n, sel2_n, we_n, oe_n,
  input wire logic [26:0] addr,
  input wire logic [31:0] din,
  output logic     [31:0] dout
);
  logic [31:0] mem [logic [27:0]];
  logic [31:0] word = 32'h0;
  wire logic [27:0] key = {sel1_n, addr};
  wire logic sel = !(sel1_n && sel2_n);
  always @(posedge we_n) if (sel) mem[key] = din;
  always @(negedge oe_n) word = mem.exists(key) ? mem[key] : 32'h0;
  // No pull on the bus: released lines show the inverse
  assign dout = (sel && !oe_n && we_n) ? word : ~word;
endmodule // mram_model
`default_nettype wire

// file: testbench/mram_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mram_port_regs.vh"
module mram_host_port_tb;
  // Edges from a take to the answer, and the shortened power-up wait
  localparam int ANSWER_EDGES = `SETUP_CYCLES + `STROBE_CYCLES;
  localparam int WAIT_EDGES   = 20;
  logic sys_clk = 0, sys_rst = 1, power_good = 1, below_cutoff = 0;
  logic req_valid = 0, req_write = 0, req_bank = 0, req_ready, rsp_valid, mem_ready, dq_oe;
  logic bank_one_select_n, bank_two_select_n, write_strobe_n, output_enable_n;
  logic [26:0] req_addr = 0, mem_addr, a;
  logic [31:0] req_wdata = 0, rsp_rdata, dq_out, dq_dev, d;
  wire logic [31:0] dq_in = dq_oe ? dq_out : dq_dev;
  logic [31:0] exp_mem [logic [27:0]];
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  mram_host_port #(
    .POWER_UP_CYCLES (WAIT_EDGES)
  ) i_mram_host_port (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .power_good        (power_good),
    .below_cutoff      (below_cutoff),
    .req_valid         (req_valid),
    .req_write         (req_write),
    .req_bank          (req_bank),
    .req_addr          (req_addr),
    .req_wdata         (req_wdata),
    .req_ready         (req_ready),
    .rsp_valid         (rsp_valid),
    .rsp_rdata         (rsp_rdata),
    .mem_ready         (mem_ready),
    .bank_one_select_n (bank_one_select_n),
    .bank_two_select_n (bank_two_select_n),
    .write_strobe_n    (write_strobe_n),
    .output_enable_n   (output_enable_n),
    .mem_addr          (mem_addr),
    .dq_out            (dq_out),
    .dq_oe             (dq_oe),
    .dq_in             (dq_in)
  );
  mram_model i_mram_model (.sel1_n(bank_one_select_n), .sel2_n(bank_two_select_n),
    .we_n(write_strobe_n), .oe_n(output_enable_n), .addr(mem_addr), .din(dq_out), .dout(dq_dev));
  always #20 sys_clk = ~sys_clk;
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Three power cycles of about two hundred edges each stay far below this
  always @(posedge sys_clk) if (++cyc > 3000)
  begin
    mismatches++;
    $display("unexpected at %0t: timeout", $time);
    give_verdict;
  end
  task chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: mismatch", $time);
    end
  endtask
  task acc(input logic w, b, input logic [26:0] ad, input logic [31:0] dt);
    int k;
    {req_valid, req_write, req_bank, req_addr, req_wdata} = {1'b1, w, b, ad, dt};
    k = 0;
    while (req_ready !== 1'b1 && k < 99)
    begin
      @(negedge sys_clk);
      k++;
    end
    // Ready seen between edges, so the next rising edge takes the request
    @(posedge sys_clk);
    @(negedge sys_clk) req_valid = 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 20)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk(k == ANSWER_EDGES);
    if (w) exp_mem[{b, ad}] = dt;
    else chk(rsp_rdata === (exp_mem.exists({b, ad}) ? exp_mem[{b, ad}] : 32'h0));
    @(negedge sys_clk);
    chk(rsp_valid === 1'b0);
  endtask
  initial
  begin
    void'($urandom(32'h16B8));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 0;
    for (int p = 0; p < 3; p++)
    begin
      n = 0;
      while (mem_ready !== 1'b1 && n < 99)
      begin
        @(negedge sys_clk);
        n++;
      end
      chk(n >= WAIT_EDGES && n <= WAIT_EDGES + 1);
      acc(1, 0, 27'h7FFFFFF, 32'hA5A5A5A5);
      acc(1, 1, 27'h7FFFFFF, 32'h5A5A5A5A);
      acc(0, 0, 27'h7FFFFFF, 0);
      acc(0, 1, 27'h7FFFFFF, 0);
      repeat (6)
      begin
        a = 27'($urandom);
        d = $urandom;
        acc(1, d[0], a, d);
        acc(0, d[0], a, 0);
      end
      // Mid-run reset first, then cutoff, then loss of power good
      if (p == 0) sys_rst = 1;
      else if (p == 1) below_cutoff = 1;
      else power_good = 0;
      @(negedge sys_clk);
      {power_good, below_cutoff, sys_rst} = 3'b100;
      // On a supply dip the timer drops ready first, the port follows one edge later; a reset drops both at once
      @(negedge sys_clk);
      chk(mem_ready === 1'b0 && bank_one_select_n === 1'b1 && bank_two_select_n === 1'b1);
    end
    give_verdict;
  end
endmodule // mram_host_port_tb
bind mram_host_port mram_host_port_assertions i_mram_host_port_assertions (
  .sys_clk           (sys_clk),
  .sys_rst           (sys_rst),
  .power_good        (power_good),
  .below_cutoff      (below_cutoff),
  .req_valid         (req_valid),
  .req_write         (req_write),
  .req_bank          (req_bank),
  .req_ready         (req_ready),
  .rsp_valid         (rsp_valid),
  .mem_ready         (mem_ready),
  .dq_oe             (dq_oe),
  .bank_one_select_n (bank_one_select_n),
  .bank_two_select_n (bank_two_select_n),
  .write_strobe_n    (write_strobe_n),
  .output_enable_n   (output_enable_n)
);
`default_nettype wire
